// ===== psbs_ctrl.sv
// Octal PSRAM pin-side command decode, burst column sequencing and sleep control
// How it works
// RULE1: Burst config resets to 32-unit hybrid wrap.
// RULE2: Type 0 wraps within aligned length block.
// RULE3: Length code selects 16, 32, 64, page.
// RULE4: Hybrid wraps block once, then runs page.
// RULE5: Linear commands force full-page wrap.
// RULE6: Linear burst wraps to page start.
// RULE7: Host issues new command for another page.
// RULE8: Row crossing only for capable linear reads.
// RULE9: Page is 2K bytes or 1K words.
// RULE10: Enabled crossing moves into next row.
// RULE11: Row crossing pauses data 30 to 65 ns.
// RULE12: Light sleep entered on chip-select rise.
// RULE13: Register writes take one-cycle latency.
// RULE14: Low chip-select pulse wakes from light sleep.
// RULE15: Deep power-down entered on chip-select rise.
// RULE16: Low chip-select pulse leaves deep power-down.
// RULE17: Leaving deep power-down restores register defaults.
// RULE18: Host spaces deep power-down entries apart.
// RULE19: Width bit selects byte or word mode.
// RULE20: Power register write-only; burst config readable.
// RULE21: Hybrid with page length equals plain wrap.
`timescale 1ns/1ps
`default_nettype none
`include "psbs_map.svh"
module psbs_ctrl
	import psbs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic ce_n,
	input wire logic [7:0] dq_in,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	output logic dqs_oe,
	input wire logic row_cross_capable,
	output logic [14:0] array_row,
	output logic [10:0] array_col,
	output logic array_rd,
	input wire logic [7:0] array_rdata,
	output logic array_wr,
	output logic [7:0] array_wdata,
	output logic word_wide_mode,
	output logic light_sleep,
	output logic deep_power_down,
	output logic contents_lost
);
	psbs_regs_t s;
	psbs_regs_t next_s;

	logic link_edge;
	logic ce_fall;
	logic ce_rise;
	logic linear;
	logic is_read;
	logic hybrid;
	logic cross_ok;
	logic fetch_go;
	logic advance;
	logic [10:0] pmask;
	logic [10:0] lmask;
	logic [10:0] wrapped;
	logic [10:0] start_col;
	logic [7:0] rd_val;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;

	function automatic logic [10:0] psbs_page_mask(input logic word);
		psbs_page_mask = word ? `PSBS_PAGE_WORD_MASK : `PSBS_PAGE_BYTE_MASK; // RULE9
	endfunction

	function automatic logic [10:0] psbs_len_mask(input logic [1:0] code, input logic word, input logic lin);
		logic [10:0] m;
		m = psbs_page_mask(word);
		if (!lin)
		begin
			case (code) // RULE3
				2'h0: m = `PSBS_LEN16_MASK;
				2'h1: m = `PSBS_LEN32_MASK;
				2'h2: m = `PSBS_LEN64_MASK;
				default: m = psbs_page_mask(word);
			endcase
		end
		psbs_len_mask = m; // RULE5
	endfunction

	psbs_fifo #(
		.WIDTH(`PSBS_FIFO_WIDTH),
		.DEPTH(`PSBS_FIFO_DEPTH)
	) u_read_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.flush(ce_rise),
		.in_valid(fetch_go),
		.in_ready(fifo_in_ready),
		.in_data(array_rdata),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign dq_out = s.dq_out;
	assign dq_oe = s.dq_oe;
	assign dqs_out = s.dqs;
	assign dqs_oe = s.dqs_oe;
	assign array_row = s.row;
	assign array_col = s.col;
	assign array_rd = fetch_go;
	assign array_wr = s.arr_wr;
	assign array_wdata = s.wdata;
	assign word_wide_mode = s.cfg[`PSBS_CFG_WORD_BIT]; // RULE19
	assign light_sleep = s.st == PSBS_ST_LIGHT;
	assign deep_power_down = s.st == PSBS_ST_DEEP;
	assign contents_lost = s.lost;
	assign fifo_out_ready = (s.st == PSBS_ST_RDATA) & link_edge & ~s.reg_rd;

	always_comb
	begin
		next_s = s;
		next_s.lk1 = link_clk;
		next_s.lk2 = s.lk1;
		next_s.lk3 = s.lk2;
		next_s.ce1 = ce_n;
		next_s.ce2 = s.ce1;
		next_s.ce3 = s.ce2;
		next_s.dq1 = dq_in;
		next_s.dq2 = s.dq1;
		next_s.cap1 = row_cross_capable;
		next_s.cap2 = s.cap1;
		next_s.arr_wr = 1'b0;
		next_s.lost = 1'b0;

		link_edge = s.lk2 ^ s.lk3;
		ce_fall = s.ce3 & ~s.ce2;
		ce_rise = s.ce2 & ~s.ce3;
		linear = s.cmd[5:0] == `PSBS_CMD_LINEAR_LOW;
		is_read = ~s.cmd[`PSBS_CMD_WRITE_BIT];
		pmask = psbs_page_mask(s.cfg[`PSBS_CFG_WORD_BIT]);
		lmask = psbs_len_mask(s.cfg[1:0], s.cfg[`PSBS_CFG_WORD_BIT], linear);
		hybrid = s.cfg[`PSBS_CFG_TYPE_BIT] & ~linear & (s.cfg[1:0] != `PSBS_CFG_LEN_FULL); // RULE21
		cross_ok = linear & is_read & s.cfg[`PSBS_CFG_ROW_CROSS_BIT] & s.cap2; // RULE8
		wrapped = (s.col & ~lmask) | ((s.col + 11'h001) & lmask); // RULE2
		start_col = {s.col[10:8], s.dq2} & pmask;
		fetch_go = s.fetch & (s.wait_cnt == 4'h0) & fifo_in_ready;
		advance = fetch_go | s.arr_wr;

		case (s.ma)
			`PSBS_ADDR_BURST_CFG: rd_val = s.cfg; // RULE20
			`PSBS_ADDR_CAPABILITY: rd_val = {s.cap2, 7'h00};
			default: rd_val = 8'h00;
		endcase

		if (s.wait_cnt != 4'h0)
			next_s.wait_cnt = s.wait_cnt - 4'h1;

		// Column sequencing after each array access
		if (advance)
		begin
			if (cross_ok & (s.col == pmask))
			begin
				next_s.col = 11'h000; // RULE10
				next_s.row = s.row + 15'h0001;
				next_s.wait_cnt = 4'(`PSBS_ROW_CROSS_WAIT_CYC); // RULE11
			end
			else if (hybrid & ~s.hyb_done & (wrapped == s.start))
			begin
				next_s.col = ((s.col & ~lmask) + lmask + 11'h001) & pmask; // RULE4
				next_s.hyb_done = 1'b1;
			end
			else if (hybrid & s.hyb_done)
				next_s.col = (s.col + 11'h001) & pmask; // RULE4
			else
				next_s.col = wrapped & pmask; // RULE6
		end

		case (s.st)
			PSBS_ST_IDLE:
			begin
				if (ce_fall)
				begin
					next_s.st = PSBS_ST_CMD;
					next_s.idx = 4'h0;
				end
			end
			PSBS_ST_CMD:
			begin
				if (link_edge)
				begin
					next_s.idx = s.idx + 4'h1;
					case (s.idx)
						4'h0: next_s.cmd = s.dq2;
						4'h2: next_s.row[14:13] = s.dq2[1:0];
						4'h3: next_s.row[12:5] = s.dq2;
						4'h4:
						begin
							next_s.row[4:0] = s.dq2[7:3];
							next_s.col[10:8] = s.dq2[2:0];
						end
						`PSBS_CMD_LAST_EDGE:
						begin
							next_s.ma = s.dq2;
							next_s.col = start_col;
							next_s.start = start_col;
							next_s.hyb_done = 1'b0;
							next_s.reg_rd = 1'b0;
							next_s.st = PSBS_ST_LAT;
							if (s.cmd == `PSBS_CMD_REG_WRITE)
								next_s.lat = `PSBS_REG_WR_LAT_EDGES; // RULE13
							else if (s.cmd == `PSBS_CMD_REG_READ)
							begin
								next_s.lat = `PSBS_RD_LAT_EDGES;
								next_s.reg_rd = 1'b1;
								next_s.dqs_oe = 1'b1;
								next_s.dqs = 1'b0;
							end
							else if ((s.cmd[5:0] == `PSBS_CMD_SYNC_LOW) | linear)
							begin
								if (is_read)
								begin
									next_s.lat = `PSBS_RD_LAT_EDGES;
									next_s.fetch = 1'b1;
									next_s.dqs_oe = 1'b1;
									next_s.dqs = 1'b0;
								end
								else
									next_s.lat = `PSBS_WR_LAT_EDGES;
							end
							else
								next_s.st = PSBS_ST_IGNORE;
						end
						default:
						begin
						end
					endcase
				end
			end
			PSBS_ST_LAT:
			begin
				if (link_edge)
				begin
					next_s.lat = s.lat - 5'h01;
					if (s.lat == 5'h01)
						next_s.st = is_read ? PSBS_ST_RDATA : PSBS_ST_WDATA;
				end
			end
			PSBS_ST_WDATA:
			begin
				if (link_edge)
				begin
					if (s.cmd == `PSBS_CMD_REG_WRITE)
					begin
						if (s.ma == `PSBS_ADDR_BURST_CFG)
							next_s.cfg = {1'b0, s.dq2[6], 2'h0, s.dq2[3:0]}; // RULE19
						else if (s.ma == `PSBS_ADDR_POWER_MODE)
						begin
							if (s.dq2 == `PSBS_PWR_LIGHT)
								next_s.pwr = PSBS_PWR_LIGHT_REQ; // RULE12
							else if (s.dq2 == `PSBS_PWR_DEEP)
								next_s.pwr = PSBS_PWR_DEEP_REQ; // RULE15
						end
						next_s.st = PSBS_ST_IGNORE;
					end
					else
					begin
						next_s.arr_wr = 1'b1;
						next_s.wdata = s.dq2;
					end
				end
			end
			PSBS_ST_RDATA:
			begin
				if (link_edge)
				begin
					if (s.reg_rd)
					begin
						next_s.dq_out = rd_val; // RULE20
						next_s.dq_oe = 1'b1;
						next_s.dqs = ~s.dqs;
					end
					else if (fifo_out_valid)
					begin
						next_s.dq_out = fifo_out_data;
						next_s.dq_oe = 1'b1;
						next_s.dqs = ~s.dqs; // RULE11
					end
				end
			end
			PSBS_ST_IGNORE:
			begin
			end
			PSBS_ST_LIGHT:
			begin
				if (ce_fall)
					next_s.st = PSBS_ST_IGNORE; // RULE14
			end
			PSBS_ST_DEEP:
			begin
				if (ce_fall)
				begin
					next_s.st = PSBS_ST_IGNORE; // RULE16
					next_s.cfg = `PSBS_CFG_RESET; // RULE17
					next_s.lost = 1'b1; // RULE17
				end
			end
			default: next_s.st = PSBS_ST_IDLE;
		endcase

		// Chip select high ends any transfer and enters a requested power mode
		if (ce_rise & (s.st != PSBS_ST_LIGHT) & (s.st != PSBS_ST_DEEP))
		begin
			case (s.pwr)
				PSBS_PWR_LIGHT_REQ: next_s.st = PSBS_ST_LIGHT; // RULE12
				PSBS_PWR_DEEP_REQ: next_s.st = PSBS_ST_DEEP; // RULE15
				default: next_s.st = PSBS_ST_IDLE;
			endcase
			next_s.pwr = PSBS_PWR_NONE;
			next_s.fetch = 1'b0;
			next_s.reg_rd = 1'b0;
			next_s.dq_oe = 1'b0;
			next_s.dqs_oe = 1'b0;
			next_s.dqs = 1'b0;
			next_s.lat = 5'h00;
			next_s.wait_cnt = 4'h0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.cfg <= `PSBS_CFG_RESET; // RULE1
			s.ce1 <= 1'b1;
			s.ce2 <= 1'b1;
			s.ce3 <= 1'b1;
		end
		else
			s <= next_s;
	end
endmodule
`default_nettype wire

// ===== psbs_map.svh
// Register addresses, field positions, command codes and timing counts of the burst and sleep controller
`ifndef PSBS_MAP_SVH
`define PSBS_MAP_SVH
`define PSBS_ADDR_CAPABILITY 8'h03
`define PSBS_ADDR_POWER_MODE 8'h06
`define PSBS_ADDR_BURST_CFG 8'h08
`define PSBS_CFG_RESET 8'h05
`define PSBS_CFG_WORD_BIT 6
`define PSBS_CFG_ROW_CROSS_BIT 3
`define PSBS_CFG_TYPE_BIT 2
`define PSBS_CFG_LEN_FULL 2'h3
`define PSBS_CAP_ROW_CROSS_BIT 7
`define PSBS_CMD_REG_READ 8'h40
`define PSBS_CMD_REG_WRITE 8'hc0
`define PSBS_CMD_LINEAR_LOW 6'h20
`define PSBS_CMD_SYNC_LOW 6'h00
`define PSBS_CMD_WRITE_BIT 7
`define PSBS_PWR_LIGHT 8'hf0
`define PSBS_PWR_DEEP 8'hc0
`define PSBS_LEN16_MASK 11'h00f
`define PSBS_LEN32_MASK 11'h01f
`define PSBS_LEN64_MASK 11'h03f
`define PSBS_PAGE_BYTE_MASK 11'h7ff
`define PSBS_PAGE_WORD_MASK 11'h3ff
`define PSBS_CMD_LAST_EDGE 4'h5
`define PSBS_REG_WR_LAT_EDGES 5'h02
`define PSBS_RD_LAT_EDGES 5'h0a
`define PSBS_WR_LAT_EDGES 5'h0a
`define PSBS_FIFO_WIDTH 8
`define PSBS_FIFO_DEPTH 8
`define PSBS_CLK_PERIOD_PS 5000
`define PSBS_ROW_CROSS_WAIT_MIN_NS 30
`define PSBS_ROW_CROSS_WAIT_MAX_NS 65
`define PSBS_ROW_CROSS_WAIT_CYC ((`PSBS_ROW_CROSS_WAIT_MIN_NS * 1000 + `PSBS_CLK_PERIOD_PS - 1) / `PSBS_CLK_PERIOD_PS)
`define PSBS_ROW_CROSS_WAIT_MAX_CYC ((`PSBS_ROW_CROSS_WAIT_MAX_NS * 1000) / `PSBS_CLK_PERIOD_PS)
`endif

// ===== psbs_pkg.sv
// Types shared by the burst and sleep controller
package psbs_pkg;
	typedef enum logic [2:0] {PSBS_ST_IDLE, PSBS_ST_CMD, PSBS_ST_LAT, PSBS_ST_WDATA, PSBS_ST_RDATA, PSBS_ST_IGNORE,
		PSBS_ST_LIGHT, PSBS_ST_DEEP} psbs_state_t;
	typedef enum logic [1:0] {PSBS_PWR_NONE, PSBS_PWR_LIGHT_REQ, PSBS_PWR_DEEP_REQ} psbs_pwr_t;
	typedef struct packed {
		logic lk1;
		logic lk2;
		logic lk3;
		logic ce1;
		logic ce2;
		logic ce3;
		logic cap1;
		logic cap2;
		logic [7:0] dq1;
		logic [7:0] dq2;
		psbs_state_t st;
		psbs_pwr_t pwr;
		logic [7:0] cfg;
		logic [7:0] cmd;
		logic [7:0] ma;
		logic [3:0] idx;
		logic [4:0] lat;
		logic [14:0] row;
		logic [10:0] col;
		logic [10:0] start;
		logic hyb_done;
		logic fetch;
		logic reg_rd;
		logic [3:0] wait_cnt;
		logic [7:0] dq_out;
		logic dq_oe;
		logic dqs;
		logic dqs_oe;
		logic arr_wr;
		logic [7:0] wdata;
		logic lost;
	} psbs_regs_t;
endpackage

// ===== psbs_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module psbs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} psbs_fifo_regs_t;

	psbs_fifo_regs_t s;
	psbs_fifo_regs_t next_s;
	logic push;
	logic pop;

	assign in_ready = s.cnt != (AW + 1)'(DEPTH);
	assign out_valid = s.cnt != '0;
	assign out_data = s.mem[s.rp];

	always_comb
	begin
		next_s = s;
		push = in_valid & in_ready;
		pop = out_valid & out_ready;
		if (push)
		begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
		end
		if (pop)
			next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
		if (push & ~pop)
			next_s.cnt = s.cnt + 1'b1;
		else if (pop & ~push)
			next_s.cnt = s.cnt - 1'b1;
		// Flush drops everything, including a push in the same cycle
		if (flush)
		begin
			next_s.wp = '0;
			next_s.rp = '0;
			next_s.cnt = '0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end
endmodule
`default_nettype wire

// ===== psbs_ctrl_props.sv
// Checker for sleep entry and exit, row crossing and page bounds
`timescale 1ns/1ps
`default_nettype none
module psbs_ctrl_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce_n,
	input wire logic [14:0] array_row,
	input wire logic [10:0] array_col,
	input wire logic array_rd,
	input wire logic array_wr,
	input wire logic word_wide_mode,
	input wire logic light_sleep,
	input wire logic deep_power_down,
	input wire logic contents_lost
);
	logic seen;
	logic [14:0] last_row;
	logic [4:0] gap;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Idle cycles since the previous fetch of this chip-select period
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			seen <= 1'b0;
			last_row <= 15'h0;
			gap <= 5'h00;
		end
		else
		begin
			seen <= (seen || array_rd) && !ce_n;
			if (array_rd)
				last_row <= array_row;
			gap <= array_rd ? 5'h00 : (gap == 5'h1f) ? gap : gap + 5'h01;
		end
	chk_cross_wait: assert property (array_rd && seen && array_row != last_row |-> gap >= 5'h06 && gap <= 5'h0d)
		else $error("row crossing pause out of range");
	chk_cross_next: assert property (array_rd && seen && array_row != last_row |-> array_row == last_row + 15'h1 && array_col == 11'h0)
		else $error("row crossing did not go to next row start");
	chk_word_page: assert property (word_wide_mode && (array_rd || array_wr) |-> array_col <= 11'h3ff)
		else $error("column beyond word page");
	chk_sleep_entry: assert property ($rose(light_sleep) || $rose(deep_power_down) |-> ce_n && $past(ce_n))
		else $error("sleep entered while selected");
	chk_sleep_one: assert property (!(light_sleep && deep_power_down))
		else $error("two sleep modes at once");
	chk_quiet_asleep: assert property (light_sleep || deep_power_down |-> !array_rd && !array_wr)
		else $error("array access while asleep");
	chk_sleep_hold: assert property ((light_sleep || deep_power_down) && ce_n |=> light_sleep || deep_power_down)
		else $error("sleep left while deselected");
	chk_wake_fast: assert property ((light_sleep || deep_power_down) && $fell(ce_n) |-> ##[1:6] !light_sleep && !deep_power_down)
		else $error("no wake after low pulse");
	chk_lost_cause: assert property (contents_lost |-> deep_power_down || $past(deep_power_down) || $past(deep_power_down, 2))
		else $error("contents lost without deep exit");
	chk_lost_default: assert property (contents_lost |=> !word_wide_mode && !contents_lost)
		else $error("defaults not restored");
endmodule
`default_nettype wire

// ===== psbs_host_model.sv
// Host link model driving chip select, DDR link clock and bytes
`timescale 1ns/1ps
`default_nettype none
module psbs_host_model #(
	parameter int HALF_NS = 80,
	parameter int SLEEP_NS = 150000,
	parameter int DEEP_NS = 500000
) (
	output logic ce_n,
	output logic link_clk,
	output logic [7:0] dq_in,
	input wire logic [7:0] dq_out
);
	logic [7:0] rd_q[$];
	initial
	begin
		ce_n = 1'b1;
		link_clk = 1'b0;
		dq_in = 8'h00;
	end
	// One command per select; latency bytes are the inverse of data to expose early capture
	task automatic frame(input logic [7:0] cmd, input logic [31:0] adr, input int n, input logic [7:0] wd);
		logic [7:0] b;
		rd_q = {};
		ce_n <= 1'b0;
		for (int e = 0; e < n; e++)
		begin
			b = (e < 2) ? cmd : (e < 6) ? adr[8*(5-e) +: 8] : (e < ((n == 9) ? 8 : 16)) ? ~wd : wd;
			dq_in <= b;
			#(HALF_NS / 2);
			link_clk <= ~link_clk;
			#(HALF_NS / 2);
			if (e >= 16)
				rd_q.push_back(dq_out);
		end
		ce_n <= 1'b1;
		dq_in <= ~dq_in;
		#(HALF_NS);
		link_clk <= 1'b0;
		#(HALF_NS * 2);
	endtask
	task automatic sleep(input logic [7:0] v);
		if (v == 8'hc0)
			#(DEEP_NS);
		frame(8'hc0, 32'h6, 9, v);
		#((v == 8'hc0) ? DEEP_NS : SLEEP_NS);
	endtask
	task automatic wake();
		ce_n <= 1'b0;
		#(HALF_NS);
		ce_n <= 1'b1;
		#(SLEEP_NS);
	endtask
endmodule
`default_nettype wire

// ===== test_psbs_ctrl.sv
// Self-checking bench for the burst and sleep controller
`timescale 1ns/1ps
`default_nettype none
module test_psbs_ctrl;
	logic clk_sys, rst, row_cross_capable, ce_n, link_clk, dq_oe, dqs_out, dqs_oe, array_rd, array_wr;
	logic word_wide_mode, light_sleep, deep_power_down, contents_lost, dqs_q;
	logic [7:0] dq_in, dq_out, array_rdata, array_wdata;
	logic [14:0] array_row;
	logic [10:0] array_col;
	logic [25:0] acc_q[$];
	logic [25:0] wr_q[$];
	int checks = 0, fails = 0, lost_n = 0, cyc = 0, dqs_n = 0;
	assign array_rdata = array_col[7:0];
	psbs_ctrl u_dut (.clk_sys, .rst, .link_clk, .ce_n, .dq_in, .dq_out, .dq_oe, .dqs_out, .dqs_oe,
		.row_cross_capable, .array_row, .array_col, .array_rd, .array_rdata, .array_wr, .array_wdata,
		.word_wide_mode, .light_sleep, .deep_power_down, .contents_lost);
	psbs_host_model #(.SLEEP_NS(1500), .DEEP_NS(5000)) u_host (.ce_n, .link_clk, .dq_in, .dq_out);
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (array_rd === 1'b1)
			acc_q.push_back({array_row, array_col});
		if (array_wr === 1'b1)
			wr_q.push_back({7'h0, array_col, array_wdata});
		if (contents_lost === 1'b1)
			lost_n++;
		// Strobe edges seen while the device drives data and strobe
		dqs_q <= dqs_out;
		if (dq_oe === 1'b1 && dqs_oe === 1'b1 && dqs_out !== dqs_q)
			dqs_n++;
		if (cyc == 30000)
		begin
			fails++;
			results();
		end
	end
	task automatic check(input string what, input logic [25:0] exp, input logic [25:0] got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic done(input string t);
		$display("test %s ended, checks %0d fails %0d", t, checks, fails);
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] ma, input logic [7:0] v);
		u_host.frame(8'hc0, {24'h0, ma}, 9, v);
	endtask
	task automatic reg_rd(input logic [7:0] ma, input logic [7:0] exp);
		u_host.frame(8'h40, {24'h0, ma}, 17, 8'h00);
		check("register", exp, u_host.rd_q[0]);
	endtask
	// Expected column of the k-th access from start s
	function automatic logic [10:0] exp_col(input logic [10:0] s, input int k, input logic [2:0] tl,
		input logic [10:0] pm);
		logic [10:0] m;
		m = (tl[1:0] == 2'h3) ? pm : (11'h010 << tl[1:0]) - 11'h001;
		return (tl[2] && k > m) ? ((s & ~m) + 11'(k)) & pm : (s & ~m) | ((s + 11'(k)) & m);
	endfunction
	task automatic burst(input logic [7:0] cfg, input logic [7:0] cmd, input logic [25:0] rc, input logic [10:0] pm);
		int n0;
		logic [10:0] c;
		reg_wr(8'h08, cfg);
		acc_q = {};
		n0 = dqs_n;
		u_host.frame(cmd, {6'h0, rc}, 36, 8'h00);
		check("strobes", 26'h14, 26'(dqs_n - n0));
		check("release", 26'h0, {24'h0, dq_oe, dqs_oe});
		for (int k = 0; k < 20; k++)
		begin
			c = exp_col(rc[10:0], k, (cmd == 8'h20) ? 3'h3 : cfg[2:0], pm);
			check("column", {rc[25:11], c}, acc_q[k]);
			check("data", {18'h0, c[7:0]}, {18'h0, u_host.rd_q[k]});
		end
	endtask
	initial
	begin
		rst = 1'b1;
		row_cross_capable = 1'b1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reg_rd(8'h08, 8'h05);
		check("width", 1'b0, word_wide_mode);
		reg_rd(8'h06, 8'h00);
		reg_rd(8'h10, 8'h00);
		reg_rd(8'h03, 8'h80);
		reg_wr(8'h08, 8'hff);
		check("width", 1'b1, word_wide_mode);
		reg_rd(8'h08, 8'h4f);
		done("registers");
		for (int i = 0; i < 8; i++)
			burst(8'(i), 8'h00, {15'h0012, 11'h7f6}, 11'h7ff);
		burst(8'h00, 8'h20, {15'h0012, 11'h7f6}, 11'h7ff);
		burst(8'h40, 8'h20, {15'h0012, 11'h3f6}, 11'h3ff);
		burst(8'h08, 8'h00, {15'h0012, 11'h7f6}, 11'h7ff);
		@(posedge clk_sys);
		row_cross_capable <= 1'b0;
		burst(8'h08, 8'h20, {15'h0012, 11'h7f6}, 11'h7ff);
		@(posedge clk_sys);
		row_cross_capable <= 1'b1;
		done("bursts");
		acc_q = {};
		u_host.frame(8'h20, {6'h0, 15'h0012, 11'h7fe}, 36, 8'h00);
		check("row", {15'h0013, 11'h000}, acc_q[2]);
		check("row data", 26'h0, {18'h0, u_host.rd_q[2]});
		wr_q = {};
		u_host.frame(8'ha0, {6'h0, 15'h0012, 11'h7fe}, 20, 8'h5a);
		check("write", {7'h0, 11'h000, 8'h5a}, wr_q[2]);
		wr_q = {};
		u_host.frame(8'h80, {6'h0, 15'h0012, 11'h7fe}, 20, 8'ha5);
		check("sync write", {7'h0, 11'h7f0, 8'ha5}, wr_q[2]);
		wr_q = {};
		acc_q = {};
		u_host.frame(8'hff, {6'h0, 15'h0012, 11'h7fe}, 20, 8'h3c);
		check("ignored", 26'h0, 26'(wr_q.size() + acc_q.size()));
		done("crossing");
		reg_wr(8'h06, 8'h55);
		check("sleep", 1'b0, light_sleep | deep_power_down);
		u_host.sleep(8'hf0);
		check("light", 1'b1, light_sleep);
		u_host.wake();
		check("light", 1'b0, light_sleep);
		reg_rd(8'h08, 8'h08);
		reg_wr(8'h08, 8'h48);
		check("width", 1'b1, word_wide_mode);
		u_host.sleep(8'hc0);
		check("deep", 1'b1, deep_power_down);
		u_host.wake();
		check("deep", 1'b0, deep_power_down);
		check("lost", 26'h1, 26'(lost_n));
		reg_rd(8'h08, 8'h05);
		done("sleep");
		results();
	end
endmodule
bind psbs_ctrl psbs_ctrl_props u_props (.clk_sys, .rst, .ce_n, .array_row, .array_col, .array_rd, .array_wr,
	.word_wide_mode, .light_sleep, .deep_power_down, .contents_lost);
`default_nettype wire
